//--- design/spisp_defs.svh
// Purpose: Constants for the serial peripheral port core
// Assumes: 32-bit AXI4-Lite register window, word aligned
// Notes: Register offsets and field positions below
`ifndef SPISP_DEFS_SVH
`define SPISP_DEFS_SVH
`define SPISP_OFS_CTL 8'h00
`define SPISP_OFS_STAT 8'h04
`define SPISP_OFS_DATA 8'h08
`define SPISP_OFS_CRCP 8'h0c
`define SPISP_OFS_RCRC 8'h10
`define SPISP_OFS_TCRC 8'h14
`define SPISP_B_PHASE 0
`define SPISP_B_POL 1
`define SPISP_B_MASTER 2
`define SPISP_B_PSC 3
`define SPISP_B_EN 6
`define SPISP_B_LSBF 7
`define SPISP_B_SSLVL 8
`define SPISP_B_SSEN 9
`define SPISP_B_RXONLY 10
`define SPISP_B_W16 11
`define SPISP_B_CRCNXT 12
`define SPISP_B_CRCEN 13
`define SPISP_B_BDOE 14
`define SPISP_B_BDEN 15
`define SPISP_B_SSDRV 16
`define SPISP_B_FRAMED 17
`define SPISP_B_DMAT 18
`define SPISP_B_DMAR 19
`define SPISP_S_RXF 0
`define SPISP_S_TXE 1
`define SPISP_S_CRCERR 4
`define SPISP_S_FAULT 5
`define SPISP_S_RXOVR 6
`define SPISP_S_BUSY 7
`define SPISP_CTL_RST 20'h00000
`define SPISP_CRCP_RST 16'h0007
`endif

//--- design/spisp_pkg.sv
// Purpose: Types for the serial peripheral port core
// Assumes: Constants come from spisp_defs.svh
// Notes: One-hot shift engine states
package spisp_pkg;
  typedef enum logic [2:0] {
    SPISP_IDLE = 3'b001,
    SPISP_SHIFT = 3'b010,
    SPISP_DONE = 3'b100
  } spisp_state_type;
endpackage

//--- design/spisp_crc.sv
// Purpose: Serial checksum generator, one bit per call
// Assumes: Polynomial from register, width 8 or 16
// Notes: Pure combinational step
module spisp_crc (
  input wire logic [15:0] crc_in,
  input wire logic [15:0] poly,
  input wire logic bit_in,
  input wire logic wide,
  output logic [15:0] crc_out
);
  logic fb;
  always_comb begin
    fb = bit_in ^ (wide ? crc_in[15] : crc_in[7]);
    crc_out = {crc_in[14:0], 1'b0} ^ (fb ? poly : 16'h0000);
    if (!wide) begin
      crc_out[15:8] = 8'h00;
    end
  end
endmodule

//--- design/spisp_core.sv
// Purpose: Serial peripheral port, master or slave, AXI4-Lite registers
// Assumes: Link pins asynchronous to aclk, sampled by two flip-flops
// Notes: Master clock divided from aclk; checksum follows the data word
`include "spisp_defs.svh"
module spisp_core #(
  parameter int PSC_W = 3
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clk_en,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic sck_i,
  output logic sck_o,
  output logic sck_oe,
  input wire logic mosi_i,
  output logic mosi_o,
  output logic mosi_oe,
  input wire logic miso_i,
  output logic miso_o,
  output logic miso_oe,
  input wire logic chip_select_line_i,
  output logic chip_select_line_o,
  output logic chip_select_line_oe,
  output logic dma_tx_req,
  output logic dma_rx_req
);
  import spisp_pkg::*;

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic [19:0] ctl;
    logic [15:0] crc_poly;
    logic [15:0] tx_buf;
    logic tx_full;
    logic [15:0] rx_buf;
    logic rx_full;
    logic fault;
    logic ovr;
    logic crc_err;
    logic [15:0] rx_crc;
    logic [15:0] tx_crc;
    logic [15:0] sh_tx;
    logic [15:0] sh_rx;
    logic [4:0] bit_cnt;
    logic crc_phase;
    spisp_state_type st;
    logic [7:0] div_cnt;
    logic sck_lvl;
    logic edge_n;
    logic [1:0] sck_s;
    logic [1:0] mosi_s;
    logic [1:0] miso_s;
    logic [1:0] css_s;
    logic sck_prev;
    logic out_bit;
    logic aw_got;
    logic w_got;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic bvalid;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] bresp;
    logic [1:0] rresp;
  } spisp_regs_type;

  spisp_regs_type r_r;
  spisp_regs_type r_nxt;
  logic [15:0] crc_tx_step;
  logic [15:0] crc_rx_step;
  logic in_bit;

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [15:0] spisp_bitrev(input logic [15:0] v, input logic wide);
    logic [15:0] o;
    o = 16'h0000;
    for (int i = 0; i < 16; i++) begin
      o[i] = v[15 - i];
    end
    spisp_bitrev = wide ? o : {8'h00, o[15:8]};
  endfunction

  spisp_crc u_crc_tx (
    .crc_in(r_r.tx_crc),
    .poly(r_r.crc_poly),
    .bit_in(r_r.out_bit),
    .wide(r_r.ctl[`SPISP_B_W16]),
    .crc_out(crc_tx_step)
  );
  spisp_crc u_crc_rx (
    .crc_in(r_r.rx_crc),
    .poly(r_r.crc_poly),
    .bit_in(in_bit),
    .wide(r_r.ctl[`SPISP_B_W16]),
    .crc_out(crc_rx_step)
  );

  // ****************************************
  // Next state
  // ****************************************
  logic en, mst, wide, lsbf, framed, bidir, pol, pha, rxonly, sel_low, start, lead, trail;
  logic sck_rise, sck_fall, word_end;
  logic [4:0] nbits;
  logic [15:0] ld;
  logic [7:0] half;
  logic aw_hs, w_hs, ar_hs;
  logic [7:0] wa;
  logic [31:0] wd;
  logic [7:0] stat;
  always_comb begin
    r_nxt = r_r;
    en = r_r.ctl[`SPISP_B_EN];
    mst = r_r.ctl[`SPISP_B_MASTER];
    wide = r_r.ctl[`SPISP_B_W16];
    framed = r_r.ctl[`SPISP_B_FRAMED];
    lsbf = r_r.ctl[`SPISP_B_LSBF] & ~framed;
    pol = r_r.ctl[`SPISP_B_POL] & ~framed;
    pha = r_r.ctl[`SPISP_B_PHASE] & ~framed;
    bidir = r_r.ctl[`SPISP_B_BDEN];
    rxonly = r_r.ctl[`SPISP_B_RXONLY] | (bidir & ~r_r.ctl[`SPISP_B_BDOE]);
    nbits = wide ? 5'd16 : 5'd8;
    half = 8'(8'h01 << r_r.ctl[`SPISP_B_PSC +: PSC_W]);
    sel_low = r_r.ctl[`SPISP_B_SSEN] ? ~r_r.ctl[`SPISP_B_SSLVL] : ~r_r.css_s[1];
    in_bit = mst ? (bidir ? r_r.mosi_s[1] : r_r.miso_s[1]) : (bidir ? r_r.miso_s[1] : r_r.mosi_s[1]);
    sck_rise = r_r.sck_s[1] & ~r_r.sck_prev;
    sck_fall = ~r_r.sck_s[1] & r_r.sck_prev;
    lead = 1'b0;
    trail = 1'b0;
    word_end = 1'b0;
    ld = 16'h0000;
    start = 1'b0;
    // Synchronisers
    r_nxt.sck_s = {r_r.sck_s[0], sck_i};
    r_nxt.mosi_s = {r_r.mosi_s[0], mosi_i};
    r_nxt.miso_s = {r_r.miso_s[0], miso_i};
    r_nxt.css_s = {r_r.css_s[0], chip_select_line_i};
    r_nxt.sck_prev = r_r.sck_s[1];
    // ****************************************
    // Register bus
    // ****************************************
    aw_hs = s_axi_awvalid && !r_r.aw_got && !r_r.bvalid;
    w_hs = s_axi_wvalid && !r_r.w_got && !r_r.bvalid;
    ar_hs = s_axi_arvalid && !r_r.rvalid;
    wa = aw_hs ? s_axi_awaddr : r_r.aw_addr;
    wd = w_hs ? s_axi_wdata : r_r.w_data;
    stat = 8'h00;
    stat[`SPISP_S_RXF] = r_r.rx_full;
    stat[`SPISP_S_TXE] = ~r_r.tx_full;
    stat[`SPISP_S_CRCERR] = r_r.crc_err;
    stat[`SPISP_S_FAULT] = r_r.fault;
    stat[`SPISP_S_RXOVR] = r_r.ovr;
    stat[`SPISP_S_BUSY] = (r_r.st != SPISP_IDLE);
    if (r_r.bvalid && s_axi_bready) begin
      r_nxt.bvalid = 1'b0;
    end
    if (aw_hs) begin
      r_nxt.aw_got = 1'b1;
      r_nxt.aw_addr = s_axi_awaddr;
    end
    if (w_hs) begin
      r_nxt.w_got = 1'b1;
      r_nxt.w_data = s_axi_wdata;
    end
    // Write lands once address and data are both held
    if ((aw_hs || r_r.aw_got) && (w_hs || r_r.w_got)) begin
      r_nxt.aw_got = 1'b0;
      r_nxt.w_got = 1'b0;
      r_nxt.bvalid = 1'b1;
      r_nxt.bresp = 2'b00;
      if (wa == `SPISP_OFS_CTL) begin
        r_nxt.ctl = wd[19:0];
      end else if (wa == `SPISP_OFS_STAT) begin
        if (!wd[`SPISP_S_FAULT]) r_nxt.fault = 1'b0;
        if (!wd[`SPISP_S_RXOVR]) r_nxt.ovr = 1'b0;
        if (!wd[`SPISP_S_CRCERR]) r_nxt.crc_err = 1'b0;
      end else if (wa == `SPISP_OFS_DATA) begin
        r_nxt.tx_buf = wd[15:0];
        r_nxt.tx_full = 1'b1;
      end else if (wa == `SPISP_OFS_CRCP) begin
        r_nxt.crc_poly = wd[15:0];
      end
    end
    if (r_r.rvalid && s_axi_rready) begin
      r_nxt.rvalid = 1'b0;
    end
    if (ar_hs) begin
      r_nxt.rvalid = 1'b1;
      r_nxt.rresp = 2'b00;
      r_nxt.rdata = 32'h00000000;
      if (s_axi_araddr == `SPISP_OFS_CTL) begin
        r_nxt.rdata = {12'h000, r_r.ctl};
      end else if (s_axi_araddr == `SPISP_OFS_STAT) begin
        r_nxt.rdata = {24'h000000, stat};
      end else if (s_axi_araddr == `SPISP_OFS_DATA) begin
        r_nxt.rdata = {16'h0000, r_r.rx_buf};
        r_nxt.rx_full = 1'b0;
      end else if (s_axi_araddr == `SPISP_OFS_CRCP) begin
        r_nxt.rdata = {16'h0000, r_r.crc_poly};
      end else if (s_axi_araddr == `SPISP_OFS_RCRC) begin
        r_nxt.rdata = {16'h0000, r_r.rx_crc};
      end else if (s_axi_araddr == `SPISP_OFS_TCRC) begin
        r_nxt.rdata = {16'h0000, r_r.tx_crc};
      end
    end
    // Mode fault
    if (en && mst && !r_r.ctl[`SPISP_B_SSEN] && !r_r.ctl[`SPISP_B_SSDRV] && !r_r.css_s[1]) begin
      r_nxt.ctl[`SPISP_B_MASTER] = 1'b0;
      r_nxt.fault = 1'b1;
    end
    if (en && mst && r_r.ctl[`SPISP_B_SSEN] && !r_r.ctl[`SPISP_B_SSLVL]) begin
      r_nxt.ctl[`SPISP_B_MASTER] = 1'b0;
      r_nxt.fault = 1'b1;
    end
    // Shift engine
    case (r_r.st)
      SPISP_IDLE: begin
        r_nxt.sck_lvl = pol;
        if (en && mst && !r_nxt.fault) begin
          start = r_r.tx_full | rxonly;
        end else if (en && !mst && sel_low) begin
          start = 1'b1;
        end
        if (start) begin
          ld = r_r.tx_full ? r_r.tx_buf : 16'h0000;
          r_nxt.sh_tx = lsbf ? spisp_bitrev(ld, wide) : ld;
          r_nxt.tx_full = 1'b0;
          r_nxt.bit_cnt = 5'd0;
          r_nxt.div_cnt = 8'd0;
          r_nxt.edge_n = 1'b0;
          r_nxt.crc_phase = 1'b0;
          r_nxt.out_bit = wide ? r_nxt.sh_tx[15] : r_nxt.sh_tx[7];
          r_nxt.st = SPISP_SHIFT;
        end
      end
      SPISP_SHIFT: begin
        if (mst) begin
          if (r_r.div_cnt == half - 8'd1) begin
            r_nxt.div_cnt = 8'd0;
            r_nxt.sck_lvl = ~r_r.sck_lvl;
            if (!r_r.edge_n) lead = 1'b1;
            else trail = 1'b1;
            r_nxt.edge_n = ~r_r.edge_n;
          end else begin
            r_nxt.div_cnt = r_r.div_cnt + 8'd1;
          end
        end else if (!sel_low || !en) begin
          r_nxt.st = SPISP_IDLE;
        end else begin
          lead = pol ? sck_fall : sck_rise;
          trail = pol ? sck_rise : sck_fall;
        end
        // Sample on first edge when phase is zero, second when one
        if ((lead && !pha) || (trail && pha)) begin
          r_nxt.sh_rx = {r_r.sh_rx[14:0], in_bit};
          if (r_r.ctl[`SPISP_B_CRCEN] && !r_r.crc_phase) r_nxt.rx_crc = crc_rx_step;
          if (r_r.ctl[`SPISP_B_CRCEN] && !r_r.crc_phase) r_nxt.tx_crc = crc_tx_step;
          r_nxt.bit_cnt = r_r.bit_cnt + 5'd1;
          if (r_r.bit_cnt == nbits - 5'd1) word_end = 1'b1;
        end
        if (((trail && !pha) || (lead && pha)) && r_r.bit_cnt != 5'd0) begin
          r_nxt.sh_tx = {r_r.sh_tx[14:0], 1'b0};
          r_nxt.out_bit = wide ? r_r.sh_tx[14] : r_r.sh_tx[6];
        end
        if (word_end) begin
          r_nxt.st = SPISP_DONE;
        end
      end
      SPISP_DONE: begin
        begin
          ld = lsbf ? spisp_bitrev(r_r.sh_rx, wide) : (wide ? r_r.sh_rx : {8'h00, r_r.sh_rx[7:0]});
          if (!(r_r.ctl[`SPISP_B_BDEN] && r_r.ctl[`SPISP_B_BDOE])) begin
            if (r_r.crc_phase) begin
              r_nxt.crc_err = r_r.crc_err | (r_r.rx_crc != 16'h0000);
            end else if (r_r.rx_full) begin
              r_nxt.ovr = 1'b1;
            end else begin
              r_nxt.rx_buf = ld;
              r_nxt.rx_full = 1'b1;
            end
          end
          r_nxt.sck_lvl = pol;
          r_nxt.st = SPISP_IDLE;
          if (r_r.ctl[`SPISP_B_CRCNXT] && !r_r.crc_phase && !r_r.tx_full) begin
            r_nxt.ctl[`SPISP_B_CRCNXT] = 1'b0;
            r_nxt.sh_tx = r_r.tx_crc;
            r_nxt.out_bit = wide ? r_r.tx_crc[15] : r_r.tx_crc[7];
            r_nxt.crc_phase = 1'b1;
            r_nxt.bit_cnt = 5'd0;
            r_nxt.edge_n = 1'b0;
            r_nxt.st = SPISP_SHIFT;
          end
        end
      end
      default: r_nxt.st = SPISP_IDLE;
    endcase
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign s_axi_awready = !r_r.aw_got && !r_r.bvalid;
  assign s_axi_wready = !r_r.w_got && !r_r.bvalid;
  assign s_axi_bvalid = r_r.bvalid;
  assign s_axi_bresp = r_r.bresp;
  assign s_axi_arready = !r_r.rvalid;
  assign s_axi_rvalid = r_r.rvalid;
  assign s_axi_rdata = r_r.rdata;
  assign s_axi_rresp = r_r.rresp;
  assign sck_o = r_r.sck_lvl;
  assign sck_oe = r_r.ctl[`SPISP_B_MASTER];
  assign mosi_o = r_r.out_bit;
  assign mosi_oe = mst && en && !rxonly;
  assign miso_o = r_r.out_bit;
  assign miso_oe = !mst && en && sel_low && !rxonly;
  assign chip_select_line_oe = mst && !r_r.ctl[`SPISP_B_SSEN] && r_r.ctl[`SPISP_B_SSDRV];
  assign chip_select_line_o = !en;
  assign dma_tx_req = en && r_r.ctl[`SPISP_B_DMAT] && !r_r.tx_full;
  assign dma_rx_req = en && r_r.ctl[`SPISP_B_DMAR] && r_r.rx_full;

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r_r <= '0;
      r_r.ctl <= `SPISP_CTL_RST;
      r_r.crc_poly <= `SPISP_CRCP_RST;
      r_r.st <= SPISP_IDLE;
      r_r.css_s <= 2'b11;
    end else if (clk_en) begin
      r_r <= r_nxt;
    end
  end
endmodule

//--- verif/spisp_core_properties.sv
// Purpose: Port checks for the serial port core
// Assumes: Bound to every core instance
// Notes: Only core ports are watched
// ****************
// Checker
// ****************
module spisp_core_properties (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic sck_oe,
  input wire logic mosi_oe,
  input wire logic miso_oe,
  input wire logic chip_select_line_i,
  input wire logic chip_select_line_o,
  input wire logic chip_select_line_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_mosi_by_master: assert property (mosi_oe |-> sck_oe)
    else $error("MOSI driven outside master role");
  a_miso_by_slave: assert property (miso_oe |-> !sck_oe)
    else $error("MISO driven by master");
  a_one_data_dir: assert property (mosi_oe |-> !miso_oe)
    else $error("Both data lines driven");
  a_select_low_master: assert property (chip_select_line_oe && !chip_select_line_o |-> sck_oe)
    else $error("Select driven low outside master role");
  a_pin_fault_drop: assert property (sck_oe && !chip_select_line_oe && !chip_select_line_i |-> ##[1:8] !sck_oe)
    else $error("Master kept role with select pin low");
  a_fault_stays_slave: assert property ($fell(sck_oe) && !chip_select_line_i |=> !sck_oe [*8])
    else $error("Master role returned after fault");
  a_write_answered: assert property (s_axi_awvalid && s_axi_awready |-> ##[0:16] s_axi_bvalid)
    else $error("Write response missing");
  a_read_answered: assert property (s_axi_arvalid && s_axi_arready |-> ##[0:16] s_axi_rvalid)
    else $error("Read data missing");
  c_fault: cover property ($fell(sck_oe) && !chip_select_line_i);
  c_master_tx: cover property (mosi_oe);
  c_slave_tx: cover property (miso_oe);
endmodule

bind spisp_core spisp_core_properties u_props (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_bvalid,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .sck_oe, .mosi_oe, .miso_oe, .chip_select_line_i,
  .chip_select_line_o, .chip_select_line_oe);

//--- verif/spisp_slave_model.sv
// Purpose: Behavioural far-side slave
// Assumes: Frame restarts on clr pulse
// Notes: Released MISO shows inverse of last bit
// ****************
// Slave model
// ****************
`include "spisp_defs.svh"
module spisp_slave_model (
  input wire logic sck,
  input wire logic sel_n,
  input wire logic mosi,
  input wire logic clr,
  input wire logic [31:0] cfg,
  input wire logic [15:0] tx_word,
  output logic miso,
  output logic [15:0] rx_word
);
  timeunit 1ns;
  timeprecision 1ps;
  int e = 0;
  int w;
  int i;
  logic last;
  logic [15:0] sh;
  always_comb begin
    w = cfg[`SPISP_B_W16] ? 16 : 8;
    i = cfg[`SPISP_B_LSBF] ? e / 2 : w - 1 - e / 2;
  end
  always @(posedge clr) begin
    e = 0;
    sh = '0;
  end
  always @(sck) begin
    if (!sel_n) begin
      if ((e % 2) == int'(cfg[`SPISP_B_PHASE])) sh[i] = mosi;
      e = e + 1;
      if (e == 2 * w) rx_word = sh;
      if (e == 2 * w) e = 0;
    end
  end
  always @(*) if (!sel_n) last = tx_word[i];
  assign miso = sel_n ? ~last : last;
endmodule

//--- verif/tb_top.sv
// Purpose: Self-checking bench for the serial port core
// Assumes: Prescaler code 2 for the master clock
// Notes: Far side is a behavioural slave
// ****************
// Bench
// ****************
`include "spisp_defs.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic [31:0] cfg; logic [15:0] dtx; logic [15:0] mtx;} spisp_row_type;
  localparam logic [31:0] MST = 32'h00010014;
  localparam logic [31:0] EN = 32'h00000040;
  spisp_row_type rows [4] = '{'{32'h0, 16'h00a5, 16'h003c}, '{32'h83, 16'h0081, 16'h00e7},
    '{32'h801, 16'hbeef, 16'h1234}, '{32'h882, 16'hc3a5, 16'h0ff0}};
  logic aclk = '0;
  logic aresetn = '0;
  logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, rdv, s_axi_rdata, v, m_cfg = '0;
  logic s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_bready = '0, s_axi_arvalid = '0, s_axi_rready = '0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic sck_o, sck_oe, mosi_o, mosi_oe, miso_o, miso_oe, cs_o, cs_oe, m_miso;
  logic tb_sck = '0, tb_mosi = '0, tb_cs = '1, clr = '0;
  logic [15:0] m_tx = '0, m_rx, ex;
  logic [7:0] q;
  int num_errors = 0, comparisons = 0, cyc = 0, k, j;
  wire sck_w = sck_oe ? sck_o : tb_sck;
  wire mosi_w = mosi_oe ? mosi_o : tb_mosi;
  wire miso_w = miso_oe ? miso_o : m_miso;
  wire cs_w = cs_oe ? cs_o : tb_cs;
  always #25 aclk = ~aclk;
  spisp_core DUT (.aclk, .aresetn, .clk_en(1'b1), .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .sck_i(sck_w),
    .sck_o, .sck_oe, .mosi_i(mosi_w), .mosi_o, .mosi_oe, .miso_i(miso_w), .miso_o, .miso_oe,
    .chip_select_line_i(cs_w), .chip_select_line_o(cs_o), .chip_select_line_oe(cs_oe), .dma_tx_req(), .dma_rx_req());
  spisp_slave_model u_far (.sck(sck_w), .sel_n(cs_w), .mosi(mosi_w), .clr, .cfg(m_cfg), .tx_word(m_tx),
    .miso(m_miso), .rx_word(m_rx));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic pa = 1'b1;
    logic pw = 1'b1;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (pa || pw || !s_axi_bvalid) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      pa = pa && !s_axi_awready;
      pw = pw && !s_axi_wready;
    end
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    logic pa = 1'b1;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (pa || !s_axi_rvalid) begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      pa = pa && !s_axi_arready;
    end
    rdv = s_axi_rdata;
    s_axi_rready <= 1'b0;
  endtask
  task automatic wait_rx;
    rdv = '0;
    for (k = 0; k < 300 && rdv[`SPISP_S_RXF] !== 1'b1; k++) rd(`SPISP_OFS_STAT);
    rd(`SPISP_OFS_DATA);
  endtask
  task automatic final_report;
    $display("mismatches %0d of %0d compares", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 40000) begin
      num_errors++;
      final_report;
    end
  end
  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    rd(`SPISP_OFS_CTL);
    chk(rdv, 32'(`SPISP_CTL_RST));
    rd(8'h40);
    foreach (rows[n]) begin
      m_cfg <= rows[n].cfg;
      m_tx <= rows[n].mtx;
      wr(`SPISP_OFS_CTL, MST | rows[n].cfg);
      wr(`SPISP_OFS_CTL, MST | rows[n].cfg | EN);
      repeat (4) @(posedge aclk);
      chk(32'({cs_oe, cs_o}), 32'h2);
      clr <= 1'b1;
      @(posedge aclk);
      clr <= 1'b0;
      wr(`SPISP_OFS_DATA, 32'(rows[n].dtx));
      wait_rx;
      ex = rows[n].cfg[`SPISP_B_W16] ? 16'hffff : 16'h00ff;
      chk(32'(rdv[15:0]), 32'(rows[n].mtx & ex));
      chk(32'(m_rx), 32'(rows[n].dtx & ex));
      rd(`SPISP_OFS_STAT);
      chk(32'(rdv[`SPISP_S_RXF]), 32'h0);
      wr(`SPISP_OFS_CTL, MST | rows[n].cfg);
      repeat (4) @(posedge aclk);
      chk(32'(cs_w), 32'h1);
    end
    wr(`SPISP_OFS_DATA, 32'h0000003c);
    wr(`SPISP_OFS_CTL, 32'h00000240);
    v = 32'h00000096;
    for (j = 7; j >= 0; j--) begin
      tb_mosi <= v[j];
      repeat (4) @(posedge aclk);
      q[j] = miso_w;
      tb_sck <= 1'b1;
      repeat (4) @(posedge aclk);
      tb_sck <= 1'b0;
    end
    wait_rx;
    chk(32'(rdv[7:0]), 32'h96);
    chk(32'({q, mosi_oe}), 32'h78);
    wr(`SPISP_OFS_CTL, 32'h00000354);
    repeat (4) @(posedge aclk);
    chk(32'(sck_oe), 32'h1);
    wr(`SPISP_OFS_CTL, 32'h00000254);
    repeat (8) @(posedge aclk);
    rd(`SPISP_OFS_STAT);
    chk(32'({rdv[`SPISP_S_FAULT], sck_oe}), 32'h2);
    aresetn <= 1'b0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    wr(`SPISP_OFS_CTL, 32'h00000054);
    repeat (4) @(posedge aclk);
    chk(32'(sck_oe), 32'h1);
    tb_cs <= 1'b0;
    repeat (8) @(posedge aclk);
    tb_cs <= 1'b1;
    repeat (16) @(posedge aclk);
    rd(`SPISP_OFS_STAT);
    chk(32'({rdv[`SPISP_S_FAULT], sck_oe}), 32'h2);
    final_report;
  end
endmodule
